// ### hw/uirx_cfg_banks.sv
// Banked configuration registers of the serial/infrared block on an AHB-Lite slave port.
// Assumes a single master, word transfers, and level counts from the queues outside.
// Operation
// - Prescaler/lock register resets zero, reserved bits zero.
// - Baud clock is module clock over prescaler.
// - Prescaler codes: 13, 1.625, reserved, 1.0.
// - Lock blocks fallback, and legacy divisor access outside extended mode.
// - Locked legacy ports reach two scratchpad bytes outside extended mode.
// - Bank 2 offset 05h reads zero.
// - Transmit level read-only, count in bits 4-0.
// - Receive level read-only, count in bits 4-0.
// - Levels not frozen; software reads three times.
// - Revision register returns type and revision.
// - Link shadow tracks qualifying writes at 03h.
// - Queue shadow returns last queue control write.
// - Bank 3 layout: id, shadows, shared location.
// - Bank 4 holds infrared control, resets zero.
// - Infrared select: UART, reserved, half-duplex, SIR.
// - Infrared select ignored in extended mode.
// - Extended mode is bit 0 of control one.
// - Extended high divisor write reloads baud immediately.
`timescale 1ns/1ps
`include "uirx_defs.svh"

module uirx_cfg_banks
	import uirx_pkg::*;
#(
	parameter int         LEVEL_W  = 5,    // Width of the queue level counts.
	parameter logic [3:0] MOD_TYPE = 4'h5, // Module type code, value arbitrary.
	parameter logic [3:0] MOD_REV  = 4'h1  // Revision level, value arbitrary.
) (
	input  wire logic               ref_clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               hsel_in,
	input  wire logic [31:0]        haddr_in,
	input  wire logic [1:0]         htrans_in,
	input  wire logic               hwrite_in,
	input  wire logic [2:0]         hsize_in,
	input  wire logic [31:0]        hwdata_in,
	input  wire logic               hready_in,
	input  wire logic [LEVEL_W-1:0] tx_level_in,
	input  wire logic [LEVEL_W-1:0] rx_level_in,
	output logic [31:0]             hrdata_out,
	output logic                    hreadyout_out,
	output logic                    hresp_out,
	output logic                    baud_tick_out,
	output logic                    extended_mode_out,
	output logic [1:0]              infrared_mode_out,
	output logic [7:0]              link_control_out,
	output logic [7:0]              queue_control_out,
	output logic [15:0]             divisor_out
);

	// Level counts must fit below the reserved top bit of a byte.
	if (LEVEL_W < 1 || LEVEL_W > 7) begin : g_bad_width
		$error("LEVEL_W must lie between 1 and 7");
	end

	uirx_state_type s;   // Registered state.
	uirx_state_type n;   // Next state.
	uirx_req_type   req; // Address phase of this cycle.

	// Decode a byte at the shared location into bank and link control load.
	function automatic uirx_bank_dec_type bank_decode(input logic [7:0] wb);
		uirx_bank_dec_type r;
		r.bank  = `UIRX_BANK_0;
		r.is_lc = 1'b1;
		if (wb[7:5] == `UIRX_BANK_TAG) begin
			r.bank  = wb[2:0];
			r.is_lc = 1'b0;
		end else if (wb[`UIRX_DLAB_BIT]) begin
			r.bank = `UIRX_BANK_1;
		end
		return r;
	endfunction

	// Legacy divisor ports hit the scratchpads while locked outside extended mode.
	function automatic logic to_scratch(input uirx_state_type st);
		return st.pdl[`UIRX_LOCK_BIT] & ~st.ctrl1[`UIRX_EXT_BIT];
	endfunction

	// Read multiplexer; pure: only a legacy port read changes state, through fallback.
	function automatic logic [7:0] read_mux(input uirx_state_type st,
		input logic [2:0] off, input logic [LEVEL_W-1:0] tx, input logic [LEVEL_W-1:0] rx);
		logic [7:0] r;
		r = `UIRX_RST_BYTE;
		if (off == `UIRX_OFF_LCBS) begin
			r = st.sel_last;
		end else begin
			unique case (st.bank)
				`UIRX_BANK_0: begin
					r = `UIRX_RST_BYTE; // Data and interrupt registers live elsewhere.
				end
				`UIRX_BANK_1: begin
					if (off == `UIRX_OFF_DIV_LO) begin
						r = to_scratch(st) ? st.scr_lo : st.divisor[7:0];
					end else if (off == `UIRX_OFF_DIV_HI) begin
						r = to_scratch(st) ? st.scr_hi : st.divisor[15:8];
					end
				end
				`UIRX_BANK_2: begin
					if (off == `UIRX_OFF_DIV_LO) begin
						r = st.divisor[7:0];
					end else if (off == `UIRX_OFF_DIV_HI) begin
						r = st.divisor[15:8];
					end else if (off == `UIRX_OFF_CTRL1) begin
						r = st.ctrl1;
					end else if (off == `UIRX_OFF_PDL) begin
						r = st.pdl & `UIRX_PDL_MASK;
					end else if (off == `UIRX_OFF_TXLV) begin
						r = {{(8-LEVEL_W){1'b0}}, tx};
					end else if (off == `UIRX_OFF_RXLV) begin
						r = {{(8-LEVEL_W){1'b0}}, rx};
					end
				end
				`UIRX_BANK_3: begin
					if (off == `UIRX_OFF_REV_ID) begin
						r = {MOD_TYPE, MOD_REV};
					end else if (off == `UIRX_OFF_LCS) begin
						r = st.link_ctl;
					end else if (off == `UIRX_OFF_QCS) begin
						r = st.queue_ctl;
					end
				end
				`UIRX_BANK_4: begin
					if (off == `UIRX_OFF_IRMC) begin
						r = st.irmc & `UIRX_IRMC_MASK;
					end
				end
				default: begin
					r = `UIRX_RST_BYTE; // Banks 5 to 7 are not served here.
				end
			endcase
		end
		return r;
	endfunction

	// Address phase: only mapped, word-sized, aligned transfers take effect.
	always_comb begin
		req.valid = hsel_in & htrans_in[1] & hready_in & (haddr_in[31:5] == 27'h0)
			& (haddr_in[1:0] == 2'h0) & (hsize_in == `UIRX_AHB_BYTE_SIZE);
		req.write = hwrite_in;
		req.off   = haddr_in[4:2];
	end

	// Next-state logic: write data phase, read capture, then the baud chain.
	always_comb begin
		logic [7:0]        wb;
		logic              reload;
		logic [7:0]        thr;
		logic [7:0]        sum;
		logic              legacy;
		uirx_bank_dec_type bd;
		wb     = hwdata_in[7:0];
		reload = 1'b0;
		thr    = `UIRX_PRE_T13;
		sum    = `UIRX_RST_BYTE;
		legacy = 1'b0;
		bd     = '0;
		n      = s;
		n.ready = 1'b1;
		// Data phase of a write; the byte lane is the low lane.
		if (s.wr_pend) begin
			if (s.wr_off == `UIRX_OFF_LCBS) begin
				bd = bank_decode(wb);
				n.sel_last = wb;
				n.bank     = bd.bank;
				if (bd.is_lc) begin
					n.link_ctl = wb;
				end
			end else if (s.bank == `UIRX_BANK_0 && s.wr_off == `UIRX_OFF_QCTL) begin
				n.queue_ctl = wb;
			end else if (s.bank == `UIRX_BANK_1 && s.wr_off <= `UIRX_OFF_DIV_HI) begin
				legacy = 1'b1;
				if (to_scratch(s)) begin
					// Locked: the divisor stays untouched.
					if (s.wr_off == `UIRX_OFF_DIV_LO) begin
						n.scr_lo = wb;
					end else begin
						n.scr_hi = wb;
					end
				end else if (s.wr_off == `UIRX_OFF_DIV_LO) begin
					n.divisor[7:0] = wb;
				end else begin
					n.divisor[15:8] = wb;
					reload = 1'b1;
				end
			end else if (s.bank == `UIRX_BANK_2) begin
				if (s.wr_off == `UIRX_OFF_DIV_LO) begin
					n.divisor[7:0] = wb;
				end else if (s.wr_off == `UIRX_OFF_DIV_HI) begin
					n.divisor[15:8] = wb;
					reload = 1'b1;
				end else if (s.wr_off == `UIRX_OFF_CTRL1) begin
					n.ctrl1 = wb;
				end else if (s.wr_off == `UIRX_OFF_PDL) begin
					n.pdl = wb & `UIRX_PDL_MASK;
					n.pre_acc = `UIRX_RST_BYTE; // Restart the prescaler on a new ratio.
				end
				// Offset 05h ignores writes and always reads zero.
			end else if (s.bank == `UIRX_BANK_4 && s.wr_off == `UIRX_OFF_IRMC) begin
				n.irmc = wb & `UIRX_IRMC_MASK;
			end
		end
		// A read of the legacy ports counts as an access for fallback too. The bank is
		// the one after this cycle's write, the same bank the read data comes from.
		if (req.valid && !req.write && n.bank == `UIRX_BANK_1
			&& req.off <= `UIRX_OFF_DIV_HI) begin
			legacy = 1'b1;
		end
		// Legacy access in extended mode falls back, unless the lock holds it.
		if (legacy && !s.pdl[`UIRX_LOCK_BIT]) begin
			n.ctrl1[`UIRX_EXT_BIT] = 1'b0;
		end
		// Capture for the next data phase; read from the post-write state.
		n.wr_pend = req.valid & req.write;
		n.wr_off  = req.off;
		n.rdata   = (req.valid && !req.write) ?
			read_mux(n, req.off, tx_level_in, rx_level_in) : `UIRX_RST_BYTE;
		// Infrared select counts only outside extended mode.
		n.ir_eff = n.ctrl1[`UIRX_EXT_BIT] ? 2'h0 : n.irmc[3:2];
		// Module clock enable: 24 of every 200 reference cycles.
		n.tick24 = 1'b0;
		n.acc24  = s.acc24 + `UIRX_MOD_MHZ;
		if (n.acc24 >= `UIRX_REF_MHZ) begin
			n.acc24  = n.acc24 - `UIRX_REF_MHZ;
			n.tick24 = 1'b1;
		end
		// Prescaler in eighths, so 1.625 is an exact 13/8. Reserved code acts as 13.
		if (s.pdl[5:4] == 2'h1) begin
			thr = `UIRX_PRE_T1625;
		end else if (s.pdl[5:4] == 2'h3) begin
			thr = `UIRX_PRE_T10;
		end
		n.pre_tick = 1'b0;
		if (n.tick24) begin
			sum = n.pre_acc + `UIRX_PRE_STEP;
			if (sum >= thr) begin
				n.pre_acc  = sum - thr;
				n.pre_tick = 1'b1;
			end else begin
				n.pre_acc = sum;
			end
		end
		// Baud divisor counter; a zero divisor holds the output quiet.
		n.baud_tick = 1'b0;
		if (reload) begin
			n.baud_cnt = n.divisor;
		end else if (n.pre_tick && s.divisor != `UIRX_RST_WORD) begin
			if (s.baud_cnt <= 16'h0001) begin
				n.baud_cnt  = s.divisor;
				n.baud_tick = 1'b1;
			end else begin
				n.baud_cnt = s.baud_cnt - 16'h0001;
			end
		end
	end

	// State register; every field resets to a constant.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state register; the response is always OKAY.
	assign hrdata_out        = {24'h000000, s.rdata};
	assign hreadyout_out     = s.ready;
	assign hresp_out         = 1'b0;
	assign baud_tick_out     = s.baud_tick;
	assign extended_mode_out = s.ctrl1[`UIRX_EXT_BIT];
	assign infrared_mode_out = s.ir_eff;
	assign link_control_out  = s.link_ctl;
	assign queue_control_out = s.queue_ctl;
	assign divisor_out       = s.divisor;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Reserved prescaler bits never hold a one.
	a_lock_rsvd_zero: assert property ((s.pdl & ~`UIRX_PDL_MASK) == 8'h00)
		else $error("reserved prescaler bits set");

	// With unity prescale every module clock tick feeds the baud counter.
	a_presc_unity: assert property ((s.pdl[5:4] == 2'h3 && $past(s.pdl[5:4]) == 2'h3
		&& s.tick24) |-> s.pre_tick)
		else $error("unity prescale missed a tick");

	// Divide by 13 leaves at least eight quiet cycles between prescaler ticks.
	a_presc_thirteen: assert property ((s.pdl[5:4] == 2'h0 && s.pre_tick)
		|=> !s.pre_tick [*8])
		else $error("divide by 13 ticked too soon");

	// A locked legacy low write lands in the scratchpad, not the divisor.
	a_scratch_route: assert property ((s.wr_pend && s.bank == 3'h1 && s.wr_off == 3'h0
		&& s.pdl[7] && !s.ctrl1[0]) |=> (s.scr_lo == $past(hwdata_in[7:0])
		&& $stable(s.divisor)))
		else $error("locked divisor write not routed to scratchpad");

	// Transmit level read returns the count with zero above it.
	a_tx_level: assert property ((req.valid && !req.write && !s.wr_pend && s.bank == 3'h2
		&& req.off == 3'h6) |=> hrdata_out == {{(32-LEVEL_W){1'b0}}, $past(tx_level_in)})
		else $error("transmit level read wrong");

	// Receive level read returns the count with zero above it.
	a_rx_level: assert property ((req.valid && !req.write && !s.wr_pend && s.bank == 3'h2
		&& req.off == 3'h7) |=> hrdata_out == {{(32-LEVEL_W){1'b0}}, $past(rx_level_in)})
		else $error("receive level read wrong");

	// Revision register returns the fixed code.
	a_rev_id_read: assert property ((req.valid && !req.write && !s.wr_pend && s.bank == 3'h3
		&& req.off == 3'h0) |=> hrdata_out[7:0] == {MOD_TYPE, MOD_REV})
		else $error("revision code wrong");

	// A plain link control byte shows up in the shadow one cycle on.
	a_shadow_link: assert property ((s.wr_pend && s.wr_off == 3'h3 && !hwdata_in[7])
		|=> link_control_out == $past(hwdata_in[7:0]))
		else $error("link control shadow not updated");

	// Infrared mode output stays plain UART throughout extended mode.
	a_ir_ext_quiet: assert property (extended_mode_out |-> infrared_mode_out == 2'h0)
		else $error("infrared mode active in extended mode");

	// Reserved infrared control bits never hold a one.
	a_ir_rsvd_zero: assert property ((s.irmc & ~`UIRX_IRMC_MASK) == 8'h00)
		else $error("reserved infrared bits set");

	// An extended high divisor write restarts the counter at the new divisor.
	a_divhi_reload: assert property ((s.wr_pend && s.bank == 3'h2 && s.wr_off == 3'h1)
		|=> s.baud_cnt == s.divisor && s.divisor[15:8] == $past(hwdata_in[7:0]))
		else $error("high divisor write did not reload");

	// A bank select byte switches the active bank one cycle on.
	a_bank_switch: assert property ((s.wr_pend && s.wr_off == 3'h3
		&& hwdata_in[7:5] == 3'h7) |=> s.bank == $past(hwdata_in[2:0]))
		else $error("bank select not applied");

	// A legacy port read with the lock clear falls back from extended mode.
	a_legacy_fallback: assert property ((req.valid && !req.write && !s.wr_pend
		&& s.bank == 3'h1 && req.off == 3'h0 && !s.pdl[7]) |=> !extended_mode_out)
		else $error("legacy read did not fall back");

	// A locked legacy high write lands in the scratchpad and spares the divisor.
	a_lock_hold_hi: assert property ((s.wr_pend && s.bank == 3'h1 && s.wr_off == 3'h1
		&& s.pdl[7] && !s.ctrl1[0]) |=> (s.scr_hi == $past(hwdata_in[7:0])
		&& $stable(s.divisor)))
		else $error("locked high divisor write reached the divisor");

	// The reserved bank 2 byte always reads zero.
	a_rsvd_byte: assert property ((req.valid && !req.write && !s.wr_pend
		&& s.bank == 3'h2 && req.off == 3'h5)
		|=> hrdata_out == 32'h0000_0000)
		else $error("reserved byte read not zero");

	// The queue control shadow returns the last queue control write.
	a_queue_shadow: assert property ((req.valid && !req.write && !s.wr_pend
		&& s.bank == 3'h3 && req.off == 3'h2)
		|=> hrdata_out == {24'h000000, queue_control_out})
		else $error("queue control shadow wrong");

	// Bit 0 written to control one in bank 2 drives the extended mode output.
	a_ext_select: assert property ((s.wr_pend && s.bank == 3'h2 && s.wr_off == 3'h2)
		|=> extended_mode_out == $past(hwdata_in[0]))
		else $error("extended mode select not applied");

	// Outside extended mode the infrared output follows the stored select field.
	a_ir_select: assert property (!extended_mode_out |-> infrared_mode_out == s.irmc[3:2])
		else $error("infrared select not applied");

	// The response is always OKAY; ready stands from the first edge after reset,
	// so the edge that ends reset is let through.
	a_bus_okay: assert property (!hresp_out && (!$past(rst_n_in) || hreadyout_out))
		else $error("bus response not ready and okay");

endmodule

// ### hw/uirx_defs.svh
// Constants for the banked configuration registers of the serial/infrared block.
// Assumes the including file uses the byte offsets as 3-bit register indices.
`ifndef UIRX_DEFS_SVH
`define UIRX_DEFS_SVH

// Register indices inside a bank; the byte address is four times the index.
`define UIRX_OFF_DIV_LO 3'h0
`define UIRX_OFF_DIV_HI 3'h1
`define UIRX_OFF_REV_ID 3'h0
`define UIRX_OFF_LCS    3'h1
`define UIRX_OFF_QCS    3'h2
`define UIRX_OFF_QCTL   3'h2
`define UIRX_OFF_CTRL1  3'h2
`define UIRX_OFF_IRMC   3'h2
`define UIRX_OFF_LCBS   3'h3
`define UIRX_OFF_PDL    3'h4
`define UIRX_OFF_RSVD5  3'h5
`define UIRX_OFF_TXLV   3'h6
`define UIRX_OFF_RXLV   3'h7

// Bank numbers served here.
`define UIRX_BANK_0 3'h0
`define UIRX_BANK_1 3'h1
`define UIRX_BANK_2 3'h2
`define UIRX_BANK_3 3'h3
`define UIRX_BANK_4 3'h4

// Field positions and writable masks.
`define UIRX_EXT_BIT   0
`define UIRX_LOCK_BIT  7
`define UIRX_DLAB_BIT  7
`define UIRX_PDL_MASK  8'hb0
`define UIRX_IRMC_MASK 8'h0c
`define UIRX_BANK_TAG  3'h7

// Reset values.
`define UIRX_RST_BYTE 8'h00
`define UIRX_RST_WORD 16'h0000

// Timing: reference clock 200 MHz, module clock 24 MHz, in MHz.
`define UIRX_REF_MHZ  8'hc8
`define UIRX_MOD_MHZ  8'h18
// Prescaler accumulator works in eighths of a module clock.
`define UIRX_PRE_STEP 8'h08
`define UIRX_PRE_T13  8'h68
`define UIRX_PRE_T1625 8'h0d
`define UIRX_PRE_T10  8'h08

// Bus transfer size.
`define UIRX_AHB_BYTE_SIZE 3'h2

`endif

// ### hw/uirx_pkg.sv
// Types shared by the serial/infrared configuration register block.
// Assumes uirx_defs.svh holds all numeric constants.
package uirx_pkg;

	// One accepted bus address phase.
	typedef struct packed {
		logic       valid; // Mapped single-word transfer taken.
		logic       write; // Transfer is a write.
		logic [2:0] off;   // Register index inside the bank.
	} uirx_req_type;

	// Result of decoding a byte written to the shared link control location.
	typedef struct packed {
		logic [2:0] bank;  // Bank that becomes active.
		logic       is_lc; // Byte also loads link control.
	} uirx_bank_dec_type;

	// Whole state of the block.
	typedef struct packed {
		logic [2:0]  bank;      // Active bank.
		logic [7:0]  sel_last;  // Last byte written at the shared location.
		logic [7:0]  link_ctl;  // Link control value.
		logic [7:0]  queue_ctl; // Queue control value.
		logic [15:0] divisor;   // Baud divisor.
		logic [7:0]  scr_lo;    // Scratchpad behind the low divisor port.
		logic [7:0]  scr_hi;    // Scratchpad behind the high divisor port.
		logic [7:0]  ctrl1;     // First extended control register.
		logic [7:0]  pdl;       // Prescaler and divisor lock.
		logic [7:0]  irmc;      // Infrared mode control.
		logic [1:0]  ir_eff;    // Infrared mode in effect.
		logic        wr_pend;   // Write data phase pending.
		logic [2:0]  wr_off;    // Index of the pending write.
		logic [7:0]  rdata;     // Read data for the data phase.
		logic        ready;     // Bus ready.
		logic [7:0]  acc24;     // Module clock phase accumulator.
		logic        tick24;    // Module clock enable.
		logic [7:0]  pre_acc;   // Prescaler accumulator in eighths.
		logic        pre_tick;  // Baud generator input enable.
		logic [15:0] baud_cnt;  // Baud divisor counter.
		logic        baud_tick; // Baud generator output pulse.
	} uirx_state_type;

endpackage

// ### tb/uirx_host_model.sv
// Host CPU model: single-word AHB-Lite transfers to the register block.
// Assumes hready_in carries the slave's hreadyout and clk_in is the block clock.
`timescale 1ns/1ps
module uirx_host_model (
	input  wire logic   clk_in,
	input  wire logic   hready_in,
	output logic        hsel_out,
	output logic [31:0] haddr_out,
	output logic [1:0]  htrans_out,
	output logic        hwrite_out,
	output logic [2:0]  hsize_out,
	output logic [31:0] hwdata_out,
	output logic        rd_phase_out
);
	// The bus starts idle so the slave never sees an unknown request.
	initial begin
		hsel_out = 1'b0;
		haddr_out = 32'h0000_0000;
		htrans_out = 2'b00;
		hwrite_out = 1'b0;
		hsize_out = 3'b010;
		hwdata_out = 32'h0000_0000;
		rd_phase_out = 1'b0;
	end

	// Address phase is held until hready is seen high; the released address shows
	// its inverse so a stale value can never pass for a real one.
	task automatic addr_phase(input logic [31:0] a, input logic w);
		@(posedge clk_in);
		hsel_out <= 1'b1;
		haddr_out <= a;
		htrans_out <= 2'b10;
		hwrite_out <= w;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		hsel_out <= 1'b0;
		htrans_out <= 2'b00;
		haddr_out <= ~a;
	endtask

	// Write: data stands through the data phase, then is inverted.
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		addr_phase(a, 1'b1);
		hwdata_out <= {24'h00_0000, d};
		do @(posedge clk_in); while (hready_in !== 1'b1);
		hwdata_out <= ~{24'h00_0000, d};
	endtask

	// Read: rd_phase_out marks the data phase so the bench samples hrdata.
	task automatic rd(input logic [31:0] a);
		addr_phase(a, 1'b0);
		rd_phase_out <= 1'b1;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		rd_phase_out <= 1'b0;
	endtask
endmodule

// ### tb/uirx_cfg_banks_tb.sv
// Self-checking bench for the banked configuration registers.
// Assumes the host model in uirx_host_model.sv drives the bus.
`timescale 1ns/1ps
module uirx_cfg_banks_tb;
	localparam logic [3:0] MT = 4'h9; // Module type, value arbitrary.
	localparam logic [3:0] MR = 4'h3; // Revision level, value arbitrary.
	logic        clk, rst_n, hsel, hwrite, rd_phase, hreadyout, hresp, baud_tick, ext_mode;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, ir_mode;
	logic [2:0]  hsize;
	logic [4:0]  tx_lv, rx_lv;
	logic [7:0]  lc, qc;
	logic [15:0] div;
	logic [16:0] lfsr;
	logic [31:0] exp_q[$];        // Expected read data, oldest first.
	int          n_errors, n_checks, n_ticks, cyc, want;
	int          eig[3] = '{104, 13, 8}; // Prescaler values in eighths.

	uirx_cfg_banks #(.MOD_TYPE(MT), .MOD_REV(MR)) dut (.ref_clk_in(clk), .rst_n_in(rst_n),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout), .tx_level_in(tx_lv),
		.rx_level_in(rx_lv), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
		.hresp_out(hresp), .baud_tick_out(baud_tick), .extended_mode_out(ext_mode),
		.infrared_mode_out(ir_mode), .link_control_out(lc), .queue_control_out(qc),
		.divisor_out(div));

	uirx_host_model host (.clk_in(clk), .hready_in(hreadyout), .hsel_out(hsel),
		.haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
		.hwdata_out(hwdata), .rd_phase_out(rd_phase));

	// Clock of 5 ns period.
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// Seventeen-bit shift register, so the seed fits without truncation.
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	// One comparison; four-state inequality so an unknown never matches.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run.
	task automatic wrap_up();
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Register index to byte address; reads note their expectation first.
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		host.wr({27'h000_0000, i, 2'b00}, d);
		// The write lands at the edge the host returns on; wait until it has settled.
		@(negedge clk);
	endtask
	task automatic ra(input logic [31:0] a, input logic [7:0] e);
		exp_q.push_back({24'h00_0000, e});
		host.rd(a);
	endtask
	task automatic rd(input logic [2:0] i, input logic [7:0] e);
		ra({27'h000_0000, i, 2'b00}, e);
	endtask

	// Read data is compared in the data phase against the oldest note.
	always @(posedge clk) begin
		if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
			if (exp_q.size() == 0)
				check(hrdata, 32'hffff_ffff);
			else
				check(hrdata, exp_q.pop_front());
		end
	end

	// Baud pulses are counted; a hang is cut short by the cycle ceiling.
	always @(posedge clk) begin
		cyc++;
		if (baud_tick === 1'b1)
			n_ticks++;
		if (cyc == 40000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		tx_lv = 5'h00;
		rx_lv = 5'h00;
		lfsr = 17'h125eb;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check({16'h0000, div}, 32'h0);
		check({31'h0, ext_mode}, 32'h0);
		check({30'h0, ir_mode}, 32'h0);
		// Bank 2: prescaler/lock reset, reserved bits, reserved byte.
		wr(3'h3, 8'he2);
		rd(3'h4, 8'h00);
		wr(3'h4, 8'hff);
		rd(3'h4, 8'hb0);
		rd(3'h3, 8'he2);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00);
		ra(32'h0000_0100, 8'h00);
		// Levels change between reads; each read returns the current count.
		for (int k = 0; k < 6; k++) begin
			lfsr = lfsr_next(lfsr);
			@(posedge clk);
			tx_lv <= lfsr[4:0];
			rx_lv <= lfsr[9:5];
			@(posedge clk);
			rd(3'h6, {3'b000, tx_lv});
			rd(3'h7, {3'b000, rx_lv});
		end
		wr(3'h6, 8'hff);
		rd(3'h6, {3'b000, tx_lv});
		// Divisor 1 through the extended ports, then each legal prescaler.
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		for (int k = 0; k < 3; k++) begin
			// Code 10 is reserved and never programmed by the host.
			wr(3'h4, (k == 2) ? 8'h30 : {2'b00, k[1:0], 4'h0});
			n_ticks = 0;
			repeat (2000) @(posedge clk);
			want = 2000 * 24 * 8 / (200 * eig[k]);
			check(32'(n_ticks >= want - 2 && n_ticks <= want + 2), 32'h1);
		end
		// Lock set only while extended mode is off; legacy ports hit scratchpads.
		wr(3'h4, 8'h80);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h5a);
		wr(3'h1, 8'ha5);
		rd(3'h0, 8'h5a);
		rd(3'h1, 8'ha5);
		check({16'h0000, div}, 32'h1);
		wr(3'h3, 8'he2);
		wr(3'h4, 8'h00);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h34);
		wr(3'h1, 8'h12);
		check({16'h0000, div}, 32'h1234);
		// Extended mode on, then a legacy port access falls back.
		wr(3'h3, 8'he2);
		wr(3'h2, 8'h01);
		check({31'h0, ext_mode}, 32'h1);
		wr(3'h3, 8'h80);
		rd(3'h0, 8'h34);
		check({31'h0, ext_mode}, 32'h0);
		// Bank 0 queue control, then bank 3 identity and shadows.
		wr(3'h3, 8'h03);
		wr(3'h2, 8'hc7);
		check({24'h0, qc}, 32'hc7);
		wr(3'h3, 8'he3);
		rd(3'h0, {MT, MR});
		rd(3'h1, 8'h03);
		rd(3'h2, 8'hc7);
		for (int i = 4; i < 8; i++)
			rd(i[2:0], 8'h00);
		wr(3'h0, 8'hff);
		rd(3'h0, {MT, MR});
		check({16'h0, lc, qc}, 32'h03c7);
		// Bank 4 infrared select, every code, reserved bits forced.
		wr(3'h3, 8'he4);
		rd(3'h0, 8'h00);
		rd(3'h2, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(3'h2, {4'hf, c[1:0], 2'b11});
			rd(3'h2, {4'h0, c[1:0], 2'b00});
			check({30'h0, ir_mode}, c);
		end
		wr(3'h3, 8'he2);
		wr(3'h2, 8'h01);
		check({30'h0, ir_mode}, 32'h0);
		// Second reset in mid-run.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check({15'h0, ext_mode, div}, 32'h0);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		wr(3'h3, 8'he2);
		rd(3'h4, 8'h00);
		repeat (2) @(posedge clk);
		wrap_up();
	end
endmodule
